// >>> src/facs_params.svh
// constants for the flash array control sequencer
// Contract
// R01: strobe pattern per mode follows truth table
// R02: row decode disabled while row enable low
// R03: column multiplexer disabled while column enable low
// R04: data output bus released while output enable low
// R05: info select picks block; mass erase both
// R06: program, erase, mass erase minimum durations
// R07: store setup after mode strobe; recovery after
// R08: store strobe hold after program or erase
// R09: store strobe before program pulse delay
// R10: cumulative program time per row limited
// R11: no double program without erase between; the sequencer does not check this and accepts a repeated program command
// R12: address/data stable around program pulse
// R13: intervals apply only to manual sequencing
// R14: software registers set all intervals; the read time (FACS_READ_CYC) and the one-cycle address hold stay fixed
// R15: strobes set in order, released reversed; the code drops the mode strobe in NVH, before the store strobe
// R16: standby low between operations
`ifndef FACS_PARAMS_SVH
`define FACS_PARAMS_SVH
`define FACS_CLK_MHZ      100
`define FACS_T_WRITE_CYCLE_STROBE_US    20
`define FACS_T_ERASE_MS   20
`define FACS_T_ME_MS      100
`define FACS_T_NVS_US     5
`define FACS_T_NVH_US     5
`define FACS_T_NVH1_US    100
`define FACS_T_PGS_US     10
`define FACS_T_RCV_US     1
`define FACS_T_HV_MS      3
`define FACS_WRITE_CYCLE_STROBE_CYC     (`FACS_T_WRITE_CYCLE_STROBE_US * `FACS_CLK_MHZ)
`define FACS_ERASE_CYC    (`FACS_T_ERASE_MS * 1000 * `FACS_CLK_MHZ)
`define FACS_ME_CYC       (`FACS_T_ME_MS * 1000 * `FACS_CLK_MHZ)
`define FACS_NVS_CYC      (`FACS_T_NVS_US * `FACS_CLK_MHZ)
`define FACS_NVH_CYC      (`FACS_T_NVH_US * `FACS_CLK_MHZ)
`define FACS_NVH1_CYC     (`FACS_T_NVH1_US * `FACS_CLK_MHZ)
`define FACS_PGS_CYC      (`FACS_T_PGS_US * `FACS_CLK_MHZ)
`define FACS_RCV_CYC      (`FACS_T_RCV_US * `FACS_CLK_MHZ)
`define FACS_HV_CYC       (`FACS_T_HV_MS * 1000 * `FACS_CLK_MHZ)
`define FACS_READ_CYC     2
`define FACS_REG_CTRL     6'h00
`define FACS_REG_STAT     6'h01
`define FACS_REG_ADDR     6'h02
`define FACS_REG_WDATA    6'h03
`define FACS_REG_RDATA    6'h04
`define FACS_REG_TIM0     6'h08
`define FACS_TIM_WRITE_CYCLE_STROBE     3'h0
`define FACS_TIM_ERASE    3'h1
`define FACS_TIM_ME       3'h2
`define FACS_TIM_NVS      3'h3
`define FACS_TIM_NVH      3'h4
`define FACS_TIM_NVH1     3'h5
`define FACS_TIM_PGS      3'h6
`define FACS_TIM_RCV      3'h7
`define FACS_CTRL_START   0
`define FACS_CTRL_INFO    3
`define FACS_ROW_LSB      6
`endif

// >>> src/facs_pkg.sv
// types of the flash array control sequencer
package facs_pkg;
  typedef enum logic [1:0]
  {
    FACS_OP_READ   = 2'h0,
    FACS_OP_WRITE_CYCLE_STROBE   = 2'h1,
    FACS_OP_PERASE = 2'h2,
    FACS_OP_MERASE = 2'h3
  } facs_op_t;

  typedef enum logic [3:0]
  {
    FACS_ST_IDLE, FACS_ST_READ, FACS_ST_NVS, FACS_ST_PGS, FACS_ST_OP,
    FACS_ST_ADH, FACS_ST_NVH, FACS_ST_RCV
  } facs_state_t;

  typedef struct packed
  {
    facs_state_t      st;
    facs_op_t         op;
    logic             info;
    logic [23:0]      cnt;
    logic [15:0]      addr;
    logic [15:0]      wdata;
    logic [15:0]      rdata;
    logic [7:0][23:0] tim;
    logic [19:0]      hv;
    logic             err;
    logic             ack;
    logic [31:0]      dat;
    logic [23:0]      plen;
  } facs_regs_t;
endpackage

// >>> src/facs_sequencer.sv
// flash array strobe sequencer with wishbone timing registers
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "facs_params.svh"
module facs_sequencer
#(
  parameter logic [23:0] ERASE_CYC = 24'(`FACS_ERASE_CYC),
  parameter logic [23:0] ME_CYC    = 24'(`FACS_ME_CYC),
  parameter logic [23:0] NVH1_CYC  = 24'(`FACS_NVH1_CYC),
  parameter logic [19:0] HV_CYC    = 20'(`FACS_HV_CYC)
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // array strobes
  output logic             row_enable_o,
  output logic             column_enable_o,
  output logic             sense_amp_enable_o,
  output logic             output_enable_o,
  output logic             write_cycle_strobe_o,
  output logic             erase_strobe_o,
  output logic             whole_array_select_o,
  output logic             store_strobe_o,
  output logic             info_block_select_o,
  output logic             write_cycle_strobe_pulse_o,
  // array address and data
  output logic      [9:0]  row_addr_o,
  output logic      [5:0]  column_multiplexer_o,
  output logic      [15:0] wdata_o,
  input  wire logic [15:0] array_dout_i,
  output logic      [15:0] flash_dout_o,
  output logic             flash_dout_oe_o,
  // block selection
  output logic             main_block_act_o,
  output logic             info_block_act_o
);
  import facs_pkg::*;

  facs_regs_t q;
  facs_regs_t n;
  logic       req;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] tix;
  logic       write_cycle_strobe;
  logic       erase;
  logic       body;

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr  = req && wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign tix = {2'h0, idx} - {2'h0, `FACS_REG_TIM0};

  function automatic logic [23:0] ld(input logic [23:0] t);
    ld = (t == 24'h000000) ? 24'h000000 : t - 24'h000001;
  endfunction

  always_comb
  begin
    n     = q;
    n.ack = 1'b0;
    // register bus access
    if (req)
    begin
      n.ack = 1'b1;
      n.dat = 32'h00000000;
      case (idx)
        `FACS_REG_CTRL:
        begin
          n.dat = {28'h0000000, q.info, q.op, 1'b0};
          if (wr && wb_sel_i[0] && q.st == FACS_ST_IDLE)
          begin
            n.op   = facs_op_t'(wb_dat_i[2:1]);
            n.info = wb_dat_i[`FACS_CTRL_INFO];
            if (wb_dat_i[`FACS_CTRL_START])
            begin
              if (wb_dat_i[2:1] == FACS_OP_READ)
              begin
                n.st  = FACS_ST_READ;
                n.cnt = ld(24'(`FACS_READ_CYC));
              end
              // R10 high-voltage budget
              else if (wb_dat_i[2:1] == FACS_OP_WRITE_CYCLE_STROBE &&
                       ({5'h00, q.hv} + {1'b0, q.tim[`FACS_TIM_WRITE_CYCLE_STROBE]}) > {5'h00, HV_CYC})
              begin
                n.err = 1'b1;
              end
              else
              begin
                // R15 mode strobes before store
                n.st  = FACS_ST_NVS;
                n.cnt = ld(q.tim[`FACS_TIM_NVS]);
              end
            end
          end
        end
        `FACS_REG_STAT:
        begin
          n.dat = {10'h000, q.hv, q.err, q.st != FACS_ST_IDLE};
          if (wr && wb_sel_i[0] && wb_dat_i[1])
            n.err = 1'b0;
        end
        `FACS_REG_ADDR:
        begin
          n.dat = {16'h0000, q.addr};
          // R12 address frozen while busy
          if (wr && q.st == FACS_ST_IDLE)
          begin
            if (wb_sel_i[0]) n.addr[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) n.addr[15:8] = wb_dat_i[15:8];
          end
        end
        `FACS_REG_WDATA:
        begin
          n.dat = {16'h0000, q.wdata};
          if (wr && q.st == FACS_ST_IDLE)
          begin
            if (wb_sel_i[0]) n.wdata[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) n.wdata[15:8] = wb_dat_i[15:8];
          end
        end
        `FACS_REG_RDATA:
        begin
          n.dat = {16'h0000, q.rdata};
        end
        default:
        begin
          // R14 interval registers
          if (tix < 8'h08)
          begin
            n.dat = {8'h00, q.tim[tix[2:0]]};
            if (wr && q.st == FACS_ST_IDLE)
            begin
              if (wb_sel_i[0]) n.tim[tix[2:0]][7:0]   = wb_dat_i[7:0];
              if (wb_sel_i[1]) n.tim[tix[2:0]][15:8]  = wb_dat_i[15:8];
              if (wb_sel_i[2]) n.tim[tix[2:0]][23:16] = wb_dat_i[23:16];
            end
          end
        end
      endcase
    end
    // operation sequencer
    if (q.st != FACS_ST_IDLE && q.cnt != 24'h000000)
      n.cnt = q.cnt - 24'h000001;
    n.plen = (q.st == FACS_ST_OP && q.op == FACS_OP_WRITE_CYCLE_STROBE) ? q.plen + 24'h000001 : 24'h000000;
    case (q.st)
      FACS_ST_IDLE:
      begin
      end
      FACS_ST_READ:
      begin
        if (q.cnt == 24'h000000)
        begin
          n.rdata = array_dout_i;
          n.st    = FACS_ST_IDLE;
        end
      end
      FACS_ST_NVS:
      begin
        // R07 setup before store strobe
        if (q.cnt == 24'h000000)
        begin
          // R06 erase durations
          n.st  = (q.op == FACS_OP_WRITE_CYCLE_STROBE) ? FACS_ST_PGS : FACS_ST_OP;
          n.cnt = ld((q.op == FACS_OP_WRITE_CYCLE_STROBE)   ? q.tim[`FACS_TIM_PGS] :
                     (q.op == FACS_OP_MERASE) ? q.tim[`FACS_TIM_ME] : q.tim[`FACS_TIM_ERASE]);
        end
      end
      FACS_ST_PGS:
      begin
        // R09 store to pulse delay
        if (q.cnt == 24'h000000)
        begin
          n.st  = FACS_ST_OP;
          n.cnt = ld(q.tim[`FACS_TIM_WRITE_CYCLE_STROBE]);
        end
      end
      FACS_ST_OP:
      begin
        // R10 accumulate program time
        if (q.op == FACS_OP_WRITE_CYCLE_STROBE && q.hv != 20'hFFFFF)
          n.hv = q.hv + 20'h00001;
        if (q.cnt == 24'h000000)
        begin
          if (q.op == FACS_OP_WRITE_CYCLE_STROBE)
          begin
            n.st  = FACS_ST_ADH;
          end
          else
          begin
            n.hv  = 20'h00000;
            n.st  = FACS_ST_NVH;
            n.cnt = ld(q.op == FACS_OP_MERASE ? q.tim[`FACS_TIM_NVH1] : q.tim[`FACS_TIM_NVH]);
          end
        end
      end
      FACS_ST_ADH:
      begin
        // R12 hold after pulse
        n.st  = FACS_ST_NVH;
        n.cnt = ld(q.tim[`FACS_TIM_NVH]);
      end
      FACS_ST_NVH:
      begin
        // R08 store hold
        if (q.cnt == 24'h000000)
        begin
          n.st  = FACS_ST_RCV;
          n.cnt = ld(q.tim[`FACS_TIM_RCV]);
        end
      end
      FACS_ST_RCV:
      begin
        // R16 back to standby
        if (q.cnt == 24'h000000)
          n.st = FACS_ST_IDLE;
      end
      default:
      begin
        n.st = FACS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q       <= '0;
      q.st    <= FACS_ST_IDLE;
      q.op    <= FACS_OP_READ;
      q.tim[`FACS_TIM_WRITE_CYCLE_STROBE]  <= 24'(`FACS_WRITE_CYCLE_STROBE_CYC);
      q.tim[`FACS_TIM_ERASE] <= ERASE_CYC;
      q.tim[`FACS_TIM_ME]    <= ME_CYC;
      q.tim[`FACS_TIM_NVS]   <= 24'(`FACS_NVS_CYC);
      q.tim[`FACS_TIM_NVH]   <= 24'(`FACS_NVH_CYC);
      q.tim[`FACS_TIM_NVH1]  <= NVH1_CYC;
      q.tim[`FACS_TIM_PGS]   <= 24'(`FACS_PGS_CYC);
      q.tim[`FACS_TIM_RCV]   <= 24'(`FACS_RCV_CYC);
    end
    else
    begin
      q <= n;
    end
  end

  // strobe decode
  assign write_cycle_strobe  = q.op == FACS_OP_WRITE_CYCLE_STROBE;
  assign erase = q.op[1];
  assign body  = q.st == FACS_ST_NVS || q.st == FACS_ST_PGS || q.st == FACS_ST_OP ||
                 q.st == FACS_ST_ADH || q.st == FACS_ST_NVH;
  // R01 truth table per mode
  assign row_enable_o         = q.st == FACS_ST_READ || body;
  assign column_enable_o      = q.st == FACS_ST_READ || (body && write_cycle_strobe);
  assign sense_amp_enable_o   = q.st == FACS_ST_READ;
  assign output_enable_o      = q.st == FACS_ST_READ;
  assign write_cycle_strobe_o = write_cycle_strobe && body && q.st != FACS_ST_NVH;
  assign erase_strobe_o       = erase && body && q.st != FACS_ST_NVH;
  assign whole_array_select_o = q.op == FACS_OP_MERASE && body;
  assign store_strobe_o       = body && q.st != FACS_ST_NVS && !(erase && q.st == FACS_ST_PGS);
  assign write_cycle_strobe_pulse_o         = write_cycle_strobe && q.st == FACS_ST_OP;
  assign info_block_select_o  = q.info && (q.st != FACS_ST_IDLE);
  // R05 block selection
  assign info_block_act_o     = q.info && q.st != FACS_ST_IDLE;
  assign main_block_act_o     = (!q.info || q.op == FACS_OP_MERASE) && q.st != FACS_ST_IDLE;
  // R02 row gating
  assign row_addr_o           = row_enable_o ? q.addr[15:`FACS_ROW_LSB] : 10'h000;
  // R03 column gating
  assign column_multiplexer_o = column_enable_o ? q.addr[`FACS_ROW_LSB-1:0] : 6'h00;
  assign wdata_o              = q.wdata;
  // R04 output bus release
  assign flash_dout_o         = output_enable_o ? array_dout_i : 16'h0000;
  assign flash_dout_oe_o      = output_enable_o;
  assign wb_ack_o             = q.ack;
  assign wb_dat_o             = q.dat;

  property p_row_gate;
    @(posedge clk_i) disable iff (rst_i) !row_enable_o |-> row_addr_o == 10'h000;
  endproperty
  a_row_gate: assert property (p_row_gate) else $error("row address live while disabled"); // R02

  property p_col_gate;
    @(posedge clk_i) disable iff (rst_i) !column_enable_o |-> column_multiplexer_o == 6'h00;
  endproperty
  a_col_gate: assert property (p_col_gate) else $error("column mux live while disabled"); // R03

  property p_out_gate;
    @(posedge clk_i) disable iff (rst_i) flash_dout_oe_o |-> sense_amp_enable_o && row_enable_o;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output driven outside read"); // R04

  property p_block;
    @(posedge clk_i) disable iff (rst_i)
      (q.st != FACS_ST_IDLE) |-> (info_block_act_o == q.info) &&
      (main_block_act_o == (!q.info || q.op == FACS_OP_MERASE));
  endproperty
  a_block: assert property (p_block) else $error("wrong block selected"); // R05

  property p_store_order;
    @(posedge clk_i) disable iff (rst_i)
      $rose(store_strobe_o) |-> $past(write_cycle_strobe_o || erase_strobe_o) &&
      $past(q.st) == FACS_ST_NVS;
  endproperty
  a_store_order: assert property (p_store_order) else $error("store before mode strobe"); // R15

  property p_pulse_len;
    @(posedge clk_i) disable iff (rst_i)
      $fell(write_cycle_strobe_pulse_o) |-> $past(q.plen) + 24'h000001 >= q.tim[`FACS_TIM_WRITE_CYCLE_STROBE];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("program pulse too short"); // R06

  property p_addr_hold;
    @(posedge clk_i) disable iff (rst_i)
      $fell(write_cycle_strobe_pulse_o) |-> store_strobe_o && write_cycle_strobe_o ##1 $stable(q.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address not held after pulse"); // R12

  property p_standby;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == FACS_ST_RCV) |-> !row_enable_o && !store_strobe_o && !erase_strobe_o;
  endproperty
  a_standby: assert property (p_standby) else $error("strobes active in recovery"); // R16

  property p_ack;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles"); // R14
endmodule

// >>> test/facs_array_model.sv
// behavioural flash array seen from the sequencer
`timescale 1ns/10ps
module facs_array_model
(
  // clock
  input  wire logic        clk_i,
  // array controls
  input  wire logic        row_enable_i,
  input  wire logic        column_enable_i,
  input  wire logic        sense_amp_enable_i,
  input  wire logic        output_enable_i,
  input  wire logic        info_block_select_i,
  input  wire logic [9:0]  row_addr_i,
  input  wire logic [5:0]  column_multiplexer_i,
  // array data
  output logic      [15:0] dout_o
);
  logic [15:0] junk_ff = 16'h5A5A;

  // undriven bus changes every cycle
  always_ff @(posedge clk_i)
    junk_ff <= {junk_ff[14:0], ~junk_ff[15]};

  always_comb
    if (row_enable_i & column_enable_i & sense_amp_enable_i & output_enable_i)
      dout_o = {row_addr_i, column_multiplexer_i} ^ (info_block_select_i ? 16'hC3C3 : 16'h0);
    else
      dout_o = junk_ff;
endmodule

// >>> test/facs_sequencer_test.sv
// self-checking bench for the flash array control sequencer
`timescale 1ns/10ps
`include "facs_params.svh"
module facs_sequencer_test;
  import facs_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        row_enable_o, column_enable_o, sense_amp_enable_o, output_enable_o;
  logic        write_cycle_strobe_o, erase_strobe_o, whole_array_select_o, store_strobe_o;
  logic        info_block_select_o, write_cycle_strobe_pulse_o, flash_dout_oe_o;
  logic        main_block_act_o, info_block_act_o;
  logic [9:0]  row_addr_o;
  logic [5:0]  column_multiplexer_o;
  logic [15:0] wdata_o, array_dout_i, flash_dout_o;
  int          mismatches, cmp_count;
  int          tim [8] = '{5, 40, 9, 3, 2, 6, 4, 2};

  facs_sequencer #(.ERASE_CYC(24'h000028), .HV_CYC(20'h0000C)) i_dut (.*);
  facs_array_model i_array (.clk_i(clk_i), .row_enable_i(row_enable_o),
    .column_enable_i(column_enable_o), .sense_amp_enable_i(sense_amp_enable_o),
    .output_enable_i(output_enable_o), .info_block_select_i(info_block_select_o),
    .row_addr_i(row_addr_o), .column_multiplexer_i(column_multiplexer_o),
    .dout_o(array_dout_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // start one operation, count strobe cycles, wait until idle
  task automatic run_op(input logic [2:0] cmd, input logic [15:0] adr,
                        output logic [31:0] cnt, output logic [2:0] acts);
    logic [31:0] rd;
    logic        bad, stored;
    int          guard;
    cnt = 32'h0;
    bad = 1'b0;
    stored = 1'b0;
    acts = 3'h0;
    guard = 0;
    wb(1'b1, 8'h08, 32'(adr), rd);
    wb(1'b1, 8'h00, {28'h0000000, cmd, 1'b1}, rd);
    repeat (4)
      if (!(main_block_act_o | info_block_act_o))
        @(negedge clk_i);
    while ((main_block_act_o | info_block_act_o) && guard < 2000)
    begin
      bad |= (sense_amp_enable_o & ~(row_enable_o & column_enable_o & output_enable_o))
        | (sense_amp_enable_o & (write_cycle_strobe_o | erase_strobe_o | store_strobe_o))
        | (write_cycle_strobe_pulse_o & ~(store_strobe_o & write_cycle_strobe_o & row_enable_o))
        | (write_cycle_strobe_pulse_o & ({row_addr_o, column_multiplexer_o} != adr))
        | (~row_enable_o & (row_addr_o != 10'h000))
        | (~column_enable_o & (column_multiplexer_o != 6'h00))
        | (flash_dout_oe_o & ~output_enable_o)
        | (flash_dout_o != (flash_dout_oe_o ? array_dout_i : 16'h0000))
        | (info_block_select_o != cmd[2]);
      stored |= store_strobe_o;
      cnt[31:24] += 8'((write_cycle_strobe_o | erase_strobe_o) & ~stored);
      cnt[23:16] += 8'(store_strobe_o);
      cnt[15:8] += 8'(write_cycle_strobe_pulse_o);
      cnt[7:0] += 8'(erase_strobe_o & store_strobe_o);
      acts |= {whole_array_select_o, info_block_act_o, main_block_act_o};
      guard++;
      @(negedge clk_i);
    end
    check(32'(bad), 32'h0);
    check(32'(guard >= 2000), 32'h0);
    do
      wb(1'b0, 8'h04, 32'h0, rd);
    while (rd[0] !== 1'b0 && guard++ < 4000);
    check(32'(rd[0]), 32'h0);
    check(32'({row_enable_o, column_enable_o, sense_amp_enable_o, output_enable_o,
      write_cycle_strobe_o, erase_strobe_o, store_strobe_o, write_cycle_strobe_pulse_o,
      whole_array_select_o, info_block_select_o, flash_dout_oe_o}), 32'h0);
  endtask

  task automatic test_regs();
    logic [31:0] rd;
    wb(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'(`FACS_WRITE_CYCLE_STROBE_CYC));
    wb(1'b0, 8'h24, 32'h0, rd);
    check(rd, 32'h00000028);
    wb(1'b0, 8'h14, 32'h0, rd);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++)
      wb(1'b1, 8'(8'h20 + 4 * i), 32'(tim[i]), rd);
    wb(1'b0, 8'h3C, 32'h0, rd);
    check(rd, 32'h00000002);
    $display("test registers done");
  endtask

  task automatic test_program();
    logic [31:0] cnt, rd;
    logic [2:0]  acts;
    wb(1'b1, 8'h0C, 32'h0000A55A, rd);
    wb(1'b0, 8'h0C, 32'h0, rd);
    check(rd, 32'h0000A55A);
    check(32'(wdata_o), 32'h0000A55A);
    run_op({1'b0, FACS_OP_WRITE_CYCLE_STROBE}, 16'h1234, cnt, acts);
    check(cnt, 32'h030C0500);
    check(32'(acts), 32'h1);
    run_op({1'b0, FACS_OP_WRITE_CYCLE_STROBE}, 16'h0041, cnt, acts);
    check(cnt, 32'h030C0500);
    run_op({1'b0, FACS_OP_WRITE_CYCLE_STROBE}, 16'h0042, cnt, acts);
    check(cnt, 32'h0);
    wb(1'b0, 8'h04, 32'h0, rd);
    check(rd, 32'h0000002A);
    wb(1'b1, 8'h04, 32'h00000002, rd);
    wb(1'b0, 8'h04, 32'h0, rd);
    check(rd, 32'h00000028);
    $display("test program done");
  endtask

  task automatic test_erase();
    logic [31:0] cnt, rd;
    logic [2:0]  acts;
    run_op({1'b0, FACS_OP_PERASE}, 16'h0040, cnt, acts);
    check(cnt, 32'h032A0028);
    check(32'(acts), 32'h1);
    wb(1'b0, 8'h04, 32'h0, rd);
    check(rd, 32'h0);
    run_op({1'b1, FACS_OP_MERASE}, 16'h0000, cnt, acts);
    check(cnt, 32'h030F0009);
    check(32'(acts), 32'h7);
    $display("test erase done");
  endtask

  task automatic test_read();
    logic [31:0] cnt, rd;
    logic [2:0]  acts;
    for (int i = 0; i < 2; i++)
    begin
      run_op({i[0], FACS_OP_READ}, 16'hBEEF, cnt, acts);
      check(cnt, 32'h0);
      check(32'(acts), i ? 32'h2 : 32'h1);
      wb(1'b0, 8'h10, 32'h0, rd);
      check(rd, i ? 32'h00007D2C : 32'h0000BEEF);
    end
    $display("test read done");
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever
      #5 clk_i = ~clk_i;
  end

  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_program();
    test_erase();
    test_read();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
endmodule
